// >>> dv/tb_vpic_ctrl.sv
`timescale 1ns/1ps
module tb_vpic_ctrl;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [3:0] extPin, periphReq, irqLevel;
	logic [4:0] trapReq;
	logic [1:0] auxTrapReq;
	logic swHardTrap, irqValid, altVectorTable;
	logic [7:0] irqVector;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	vpic_ctrl i_vpic_ctrl (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .extPin(extPin),
		.periphReq(periphReq), .trapReq(trapReq), .auxTrapReq(auxTrapReq),
		.swHardTrap(swHardTrap), .irqValid(irqValid), .irqVector(irqVector),
		.irqLevel(irqLevel), .altVectorTable(altVectorTable));
	vpic_src_model i_vpic_src_model (.clk(clk), .extPin(extPin),
		.periphReq(periphReq), .trapReq(trapReq), .auxTrapReq(auxTrapReq),
		.swHardTrap(swHardTrap));
	always #2 clk = ~clk;
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	// Sized so a stalled handshake cannot run away
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic chk16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk16
	// Vector and level only matter while a request is shown
	task automatic chkIrq(input string what, input logic v,
		input logic [7:0] vec, input logic [3:0] lvl);
		if (v)
			chk16(what, {4'h8, lvl, vec}, {irqValid, 3'h0, irqLevel, irqVector});
		else
			chk16(what, 16'h0000, {15'h0000, irqValid});
	endtask : chkIrq
	task automatic axWrite(input logic [7:0] addr, input logic [15:0] data,
		input logic [1:0] resp);
		@(posedge clk);
		awaddr <= {24'h000000, addr};
		wdata <= {16'h0000, data};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk16("write response", {14'h0000, resp}, {14'h0000, bresp});
		repeat (3) @(posedge clk);
	endtask : axWrite
	task automatic rdChk(input string what, input logic [7:0] addr,
		input logic [15:0] exp, input logic [1:0] resp);
		@(posedge clk);
		araddr <= {24'h000000, addr};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk16("read response", {14'h0000, resp}, {14'h0000, rresp});
		chk16("upper half", 16'h0000, rdata[31:16]);
		chk16(what, exp, rdata[15:0]);
	endtask : rdChk
	localparam logic [1:0] OK = vpic_pkg::RESP_OK;
	initial begin
		{awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid} = '0;
		rready = 1'b0;
		wstrb = 4'h3;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdChk("ctrl2 reset", vpic_pkg::OFS_CTRL2, vpic_pkg::CTRL2_RST, OK);
		axWrite(8'h40, 16'h1234, vpic_pkg::RESP_SLVERR);
		rdChk("unmapped", 8'h40, 16'h0000, vpic_pkg::RESP_SLVERR);
		axWrite(vpic_pkg::OFS_CTRL2, 16'hFFFF, OK);
		rdChk("ctrl2 bits", vpic_pkg::OFS_CTRL2, vpic_pkg::CTRL2_MASK, OK);
		chk16("alt table on", 16'h0001, {15'h0000, altVectorTable});
		axWrite(vpic_pkg::OFS_CTRL2, 16'h8000, OK);
		chk16("alt table off", 16'h0000, {15'h0000, altVectorTable});
		axWrite(vpic_pkg::OFS_PRIO0, 16'h002D, OK);
		rdChk("prio0", vpic_pkg::OFS_PRIO0, 16'h002D, OK);
		i_vpic_src_model.setPin(0, 1'b1);
		repeat (4) @(posedge clk);
		rdChk("flag ext0", vpic_pkg::OFS_FLAG, 16'h0001, OK);
		chkIrq("disabled source", 1'b0, 8'h00, 4'h0);
		axWrite(vpic_pkg::OFS_ENABLE, 16'h0003, OK);
		chkIrq("ext0 forwarded", 1'b1, vpic_pkg::VEC_USER0, 4'h5);
		rdChk("pending", vpic_pkg::OFS_PEND, 16'h0508, OK);
		i_vpic_src_model.setPin(0, 1'b0);
		i_vpic_src_model.pulse(4'h1, 5'h00, 2'h0, 1'b0);
		repeat (4) @(posedge clk);
		rdChk("flag capture1", vpic_pkg::OFS_FLAG, 16'h0003, OK);
		chkIrq("tie to lower vec", 1'b1, vpic_pkg::VEC_USER0, 4'h5);
		axWrite(vpic_pkg::OFS_STATUS, 16'h00A0, OK);
		rdChk("cpu level", vpic_pkg::OFS_STATUS, 16'h00A0, OK);
		chkIrq("equal level", 1'b0, 8'h00, 4'h0);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h8000, OK);
		axWrite(vpic_pkg::OFS_STATUS, 16'h0080, OK);
		rdChk("level locked", vpic_pkg::OFS_STATUS, 16'h00A0, OK);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h0000, OK);
		axWrite(vpic_pkg::OFS_STATUS, 16'h0080, OK);
		chkIrq("below prio", 1'b1, vpic_pkg::VEC_USER0, 4'h5);
		axWrite(vpic_pkg::OFS_FLAG, 16'h0002, OK);
		chkIrq("capture1 left", 1'b1, 8'h09, 4'h5);
		axWrite(vpic_pkg::OFS_FLAG, 16'h0000, OK);
		chkIrq("flags cleared", 1'b0, 8'h00, 4'h0);
		axWrite(vpic_pkg::OFS_CTRL2, 16'h8001, OK);
		i_vpic_src_model.setPin(0, 1'b1);
		repeat (4) @(posedge clk);
		rdChk("no rise trigger", vpic_pkg::OFS_FLAG, 16'h0000, OK);
		i_vpic_src_model.setPin(0, 1'b0);
		repeat (4) @(posedge clk);
		rdChk("fall trigger", vpic_pkg::OFS_FLAG, 16'h0001, OK);
		axWrite(vpic_pkg::OFS_CTRL2, 16'h0000, OK);
		chkIrq("global off", 1'b0, 8'h00, 4'h0);
		i_vpic_src_model.pulse(4'h0, 5'h01, 2'h3, 1'b0);
		repeat (4) @(posedge clk);
		chkIrq("trap passes", 1'b1, vpic_pkg::VEC_OSC_FAIL, 4'hF);
		rdChk("trap flag", vpic_pkg::OFS_CTRL1, 16'h0001, OK);
		rdChk("aux traps", vpic_pkg::OFS_CTRL3, 16'h0003, OK);
		axWrite(vpic_pkg::OFS_CORE, 16'h0000, OK);
		rdChk("high level bit", vpic_pkg::OFS_CORE, 16'h0008, OK);
		axWrite(vpic_pkg::OFS_CTRL2, 16'h2000, OK);
		i_vpic_src_model.pulse(4'h0, 5'h00, 2'h0, 1'b1);
		repeat (4) @(posedge clk);
		rdChk("soft hard trap", vpic_pkg::OFS_CTRL4, 16'h0001, OK);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h0000, OK);
		chkIrq("hard trap", 1'b1, vpic_pkg::VEC_HARD, 4'hF);
		axWrite(vpic_pkg::OFS_CTRL3, 16'h0000, OK);
		axWrite(vpic_pkg::OFS_CTRL4, 16'h0000, OK);
		i_vpic_src_model.pulse(4'h0, 5'h1E, 2'h0, 1'b0);
		repeat (4) @(posedge clk);
		chkIrq("addr trap", 1'b1, vpic_pkg::VEC_ADDR_ERR, 4'hF);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h001C, OK);
		chkIrq("stack trap", 1'b1, vpic_pkg::VEC_STACK, 4'hF);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h0018, OK);
		chkIrq("math trap", 1'b1, vpic_pkg::VEC_MATH, 4'hF);
		axWrite(vpic_pkg::OFS_CTRL1, 16'h0010, OK);
		chkIrq("soft trap", 1'b1, vpic_pkg::VEC_SOFT, 4'hF);
		test_done();
	end
endmodule : tb_vpic_ctrl

// >>> dv/vpic_src_model.sv
`timescale 1ns/1ps
module vpic_src_model (
	input wire logic clk,
	output logic [3:0] extPin,
	output logic [3:0] periphReq,
	output logic [4:0] trapReq,
	output logic [1:0] auxTrapReq,
	output logic swHardTrap
);
	initial begin
		extPin = 4'h0;
		periphReq = 4'h0;
		trapReq = 5'h00;
		auxTrapReq = 2'h0;
		swHardTrap = 1'b0;
	end
	// Level held long enough to pass the two-flop synchroniser
	task automatic setPin(input int idx, input logic lvl);
		@(posedge clk);
		extPin[idx] <= lvl;
		repeat (3) @(posedge clk);
	endtask : setPin
	// Peripheral strobes last one cycle only, the hardest case
	task automatic pulse(input logic [3:0] p, input logic [4:0] t,
		input logic [1:0] a, input logic sw);
		@(posedge clk);
		periphReq <= p;
		trapReq <= t;
		auxTrapReq <= a;
		swHardTrap <= sw;
		@(posedge clk);
		periphReq <= 4'h0;
		trapReq <= 5'h00;
		auxTrapReq <= 2'h0;
		swHardTrap <= 1'b0;
	endtask : pulse
endmodule : vpic_src_model

// >>> hdl/vpic_arbiter.sv
`timescale 1ns/1ps
module vpic_arbiter (
	vpic_req_if.arb bus
);
	always_comb begin
		bus.bestValid = 1'b0;
		bus.bestVec = vpic_pkg::VEC_NONE;
		bus.bestLevel = 4'h0;
		if (bus.trapValid) begin
			bus.bestValid = 1'b1;
			bus.bestVec = bus.trapVec;
			bus.bestLevel = 4'hF;
		end else if (bus.globalEnable && !bus.cpuLevel[3]) begin // [R11] [R8]
			// Descending scan keeps the lowest vector on ties
			for (int i = vpic_pkg::NSRC - 1; i >= 0; i--) begin
				if (bus.flag[i] && bus.enable[i]
					&& {1'b0, bus.prio[3*i +: 3]} > bus.cpuLevel
					&& {1'b0, bus.prio[3*i +: 3]} >= bus.bestLevel) begin // [R16] [R2]
					bus.bestValid = 1'b1;
					bus.bestVec = vpic_pkg::VEC_USER0 + 8'(i);
					bus.bestLevel = {1'b0, bus.prio[3*i +: 3]};
				end
			end
		end
	end
endmodule : vpic_arbiter

// >>> hdl/vpic_ctrl.sv
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// [R1] Each source has a sticky request flag set by hardware, cleared by software.
// [R2] A request counts only while the source enable bit is set.
// [R3] Each user source has a 3-bit priority, levels one to seven.
// [R4] Flags, enables, priorities packed in vector order; ext0 at bit 0.
// [R5] Pending vector and new level latched read-only; top nibble zero.
// [R6] Vectors: traps 0-4,6; ext0 is 8; capture1 is 9.
// [R7] CPU level bits sit at status bits 7:5, software writable.
// [R8] Level 7 or high level bit set blocks user interrupts.
// [R9] High CPU level bit is read-only to software.
// [R10] Nesting disable set makes the CPU level bits read-only.
// [R11] Global enable resets to one; clearing blocks interrupts, not traps.
// [R12] Control two bit 8 selects the alternate vector table.
// [R13] External 0,1,2,4 polarity bits: one falling edge, zero rising.
// [R14] Control three holds PLL and loop-stack trap flags; one holds traps.
// [R15] Control four flags a software-generated hard trap.
// [R16] Forward only flagged, enabled, globally enabled, above CPU level.
module vpic_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] extPin,
	input wire logic [3:0] periphReq,
	input wire logic [4:0] trapReq,
	input wire logic [1:0] auxTrapReq,
	input wire logic swHardTrap,
	output logic irqValid,
	output logic [7:0] irqVector,
	output logic [3:0] irqLevel,
	output logic altVectorTable
);
	vpic_req_if rq ();
	vpic_arbiter i_vpic_arbiter (.bus(rq));

	logic [15:0] cpuStatus, ctrl1, ctrl2, ctrl3, ctrl4, pendStatus;
	logic [7:0] flag, enable;
	logic [23:0] prio;
	logic coreHigh;
	logic [15:0] next_cpuStatus, next_ctrl1, next_ctrl2, next_ctrl3;
	logic [15:0] next_ctrl4, next_pendStatus;
	logic [7:0] next_flag, next_enable;
	logic [23:0] next_prio;
	logic [3:0] extS1, extS2, extS3;
	logic [7:0] hwSet;
	logic [3:0] extEdge;
	logic [3:0] polarity;

	// Two flops on pins, third for edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extS1 <= 4'h0;
			extS2 <= 4'h0;
			extS3 <= 4'h0;
		end else begin
			extS1 <= extPin;
			extS2 <= extS1;
			extS3 <= extS2;
		end
	end

	assign polarity = {ctrl2[4], ctrl2[2], ctrl2[1], ctrl2[0]};
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			extEdge[i] = polarity[i] ? (extS3[i] & ~extS2[i])
				: (~extS3[i] & extS2[i]); // [R13]
		end
	end
	// Sources in vector order: ext0, capture1, then the rest
	assign hwSet = {extEdge[3:2], periphReq[3:1], extEdge[1],
		periphReq[0], extEdge[0]}; // [R4]

	// AXI write path
	typedef enum logic [1:0] {VP_IDLE = 2'b00, VP_RESP = 2'b01} vpic_wst_t;
	vpic_wst_t wState, next_wState;
	logic awHeld, wHeld, next_awHeld, next_wHeld;
	logic [7:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic next_bvalid, next_awready, next_wready;
	logic [1:0] next_bresp;
	logic doWrite;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= vpic_pkg::OFS_CORE);
	endfunction : mapped

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	always_comb begin
		next_wState = wState;
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		doWrite = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		unique case (wState)
			VP_IDLE: begin
				if (awHeld && wHeld) begin
					doWrite = mapped(awAddr);
					next_bresp = mapped(awAddr) ? vpic_pkg::RESP_OK
						: vpic_pkg::RESP_SLVERR;
					next_bvalid = 1'b1;
					next_wState = VP_RESP;
				end
			end
			VP_RESP: begin
				if (s_axi_bready) begin
					next_bvalid = 1'b0;
					next_awHeld = 1'b0;
					next_wHeld = 1'b0;
					next_wState = VP_IDLE;
				end
			end
			default: next_wState = VP_IDLE;
		endcase
		next_awready = !next_awHeld;
		next_wready = !next_wHeld;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wState <= VP_IDLE;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			wState <= next_wState;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
		end
	end

	logic [15:0] mStat, mFlag, mEn, mPr0, mPr1;
	assign mStat = merge(cpuStatus, wData, wStrb);
	assign mFlag = merge({8'h00, flag}, wData, wStrb);
	assign mEn = merge({8'h00, enable}, wData, wStrb);
	assign mPr0 = merge({4'h0, prio[11:0]}, wData, wStrb);
	assign mPr1 = merge({4'h0, prio[23:12]}, wData, wStrb);
	// Register file; hardware set beats software clear
	always_comb begin
		next_cpuStatus = cpuStatus;
		next_ctrl1 = ctrl1;
		next_ctrl2 = ctrl2;
		next_ctrl3 = ctrl3;
		next_ctrl4 = ctrl4;
		next_flag = flag;
		next_enable = enable;
		next_prio = prio;
		if (doWrite) begin
			unique case (awAddr)
				vpic_pkg::OFS_STATUS: next_cpuStatus =
					ctrl1[vpic_pkg::NEST_BIT] ? {mStat[15:8], // [R10]
					cpuStatus[7:5], mStat[4:0]} : mStat; // [R7]
				vpic_pkg::OFS_CTRL1: next_ctrl1 = merge(ctrl1, wData, wStrb); // [R14]
				vpic_pkg::OFS_CTRL2: next_ctrl2 = merge(ctrl2, wData, wStrb)
					& vpic_pkg::CTRL2_MASK; // [R12]
				vpic_pkg::OFS_CTRL3: next_ctrl3 = merge(ctrl3, wData, wStrb);
				vpic_pkg::OFS_CTRL4: next_ctrl4 = merge(ctrl4, wData, wStrb);
				vpic_pkg::OFS_FLAG: next_flag = mFlag[7:0];
				vpic_pkg::OFS_ENABLE: next_enable = mEn[7:0]; // [R2]
				vpic_pkg::OFS_PRIO0: next_prio[11:0] = mPr0[11:0]; // [R3]
				vpic_pkg::OFS_PRIO1: next_prio[23:12] = mPr1[11:0];
				default: begin
				end
			endcase
		end
		next_flag = next_flag | hwSet; // [R1]
		next_ctrl1[4:0] = next_ctrl1[4:0] | trapReq; // [R14]
		next_ctrl3[1:0] = next_ctrl3[1:0] | auxTrapReq; // [R14]
		next_ctrl4[vpic_pkg::SOFT_HARD_TRAP_FLAG_BIT] = next_ctrl4[vpic_pkg::SOFT_HARD_TRAP_FLAG_BIT]
			| (swHardTrap & ctrl2[vpic_pkg::SOFTWARE_TRAP_ENABLE_BIT]); // [R15]
	end

	// Traps: any set trap flag, fixed lowest-vector order
	always_comb begin
		rq.trapValid = 1'b1;
		rq.trapVec = vpic_pkg::VEC_NONE;
		if (ctrl1[0]) rq.trapVec = vpic_pkg::VEC_OSC_FAIL;
		else if (ctrl1[1]) rq.trapVec = vpic_pkg::VEC_ADDR_ERR;
		else if (ctrl4[0] || ctrl3[0] || ctrl3[1]) rq.trapVec = vpic_pkg::VEC_HARD;
		else if (ctrl1[2]) rq.trapVec = vpic_pkg::VEC_STACK;
		else if (ctrl1[3]) rq.trapVec = vpic_pkg::VEC_MATH;
		else if (ctrl1[4]) rq.trapVec = vpic_pkg::VEC_SOFT; // [R6]
		else rq.trapValid = 1'b0;
	end
	assign rq.flag = flag;
	assign rq.enable = enable;
	assign rq.prio = prio;
	assign rq.cpuLevel = {coreHigh, cpuStatus[7:5]}; // [R8]
	assign rq.globalEnable = ctrl2[vpic_pkg::GIE_BIT]; // [R11]

	always_comb begin
		next_pendStatus = {4'h0, rq.bestLevel, rq.bestVec}; // [R5]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuStatus <= 16'h0000;
			ctrl1 <= 16'h0000;
			ctrl2 <= vpic_pkg::CTRL2_RST; // [R11]
			ctrl3 <= 16'h0000;
			ctrl4 <= 16'h0000;
			flag <= 8'h00;
			enable <= 8'h00;
			prio <= 24'h0;
			pendStatus <= {8'h00, vpic_pkg::VEC_NONE};
			coreHigh <= 1'b0;
			irqValid <= 1'b0;
			irqVector <= vpic_pkg::VEC_NONE;
			irqLevel <= 4'h0;
			altVectorTable <= 1'b0;
		end else begin
			cpuStatus <= next_cpuStatus;
			ctrl1 <= next_ctrl1;
			ctrl2 <= next_ctrl2;
			ctrl3 <= next_ctrl3;
			ctrl4 <= next_ctrl4;
			flag <= next_flag;
			enable <= next_enable;
			prio <= next_prio;
			pendStatus <= next_pendStatus;
			coreHigh <= rq.trapValid; // [R9]
			irqValid <= rq.bestValid; // [R16]
			irqVector <= rq.bestVec;
			irqLevel <= rq.bestLevel;
			altVectorTable <= ctrl2[vpic_pkg::AIVT_BIT]; // [R12]
		end
	end

	// AXI read path
	logic [31:0] rdMux;
	always_comb begin
		unique case (s_axi_araddr[7:0])
			vpic_pkg::OFS_STATUS: rdMux = {16'h0, cpuStatus};
			vpic_pkg::OFS_CTRL1: rdMux = {16'h0, ctrl1};
			vpic_pkg::OFS_CTRL2: rdMux = {16'h0, ctrl2};
			vpic_pkg::OFS_CTRL3: rdMux = {16'h0, ctrl3};
			vpic_pkg::OFS_CTRL4: rdMux = {16'h0, ctrl4};
			vpic_pkg::OFS_PEND: rdMux = {16'h0, pendStatus}; // [R5]
			vpic_pkg::OFS_FLAG: rdMux = {24'h0, flag};
			vpic_pkg::OFS_ENABLE: rdMux = {24'h0, enable};
			vpic_pkg::OFS_PRIO0: rdMux = {20'h0, prio[11:0]};
			vpic_pkg::OFS_PRIO1: rdMux = {20'h0, prio[23:12]};
			vpic_pkg::OFS_CORE: rdMux = {28'h0, coreHigh, 3'h0};
			default: rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= mapped(s_axi_araddr[7:0]) ? vpic_pkg::RESP_OK
				: vpic_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(hwSet[0]) |=> flag[0]) else $error("flag not set"); // [R1]
	chk_gie_block: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctrl2[15] && !rq.trapValid) |=> !irqValid)
		else $error("irq with global off"); // [R11]
	chk_level_above: assert property (@(posedge clk) disable iff (!rst_n)
		(irqValid && irqVector >= 8'h08) |-> irqLevel > $past(rq.cpuLevel))
		else $error("irq not above level"); // [R16]
	chk_high_block: assert property (@(posedge clk) disable iff (!rst_n)
		$past(coreHigh) && irqValid |-> irqVector < 8'h08)
		else $error("user irq at high level"); // [R8]
	chk_pend_top: assert property (@(posedge clk) disable iff (!rst_n)
		pendStatus[15:12] == 4'h0) else $error("pending top set"); // [R5]
	chk_nest_lock: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl1[15] |=> $stable(cpuStatus[7:5]) || !$past(ctrl1[15]))
		else $error("level changed while locked"); // [R10]
	chk_alt_table: assert property (@(posedge clk) disable iff (!rst_n)
		##1 altVectorTable == $past(ctrl2[8])) else $error("alt table"); // [R12]
	chk_enable_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(irqValid && irqVector == 8'h08) |-> $past(enable[0]))
		else $error("disabled source forwarded"); // [R2]
	cov_user: cover property (@(posedge clk) irqValid && irqVector == 8'h08);
	cov_trap: cover property (@(posedge clk) irqValid && irqVector == 8'h02);
	cov_write: cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
endmodule : vpic_ctrl

// >>> hdl/vpic_pkg.sv
package vpic_pkg;
	localparam int NSRC = 8;
	localparam int DW = 16;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CTRL2 = 8'h08;
	localparam logic [7:0] OFS_CTRL3 = 8'h0C;
	localparam logic [7:0] OFS_CTRL4 = 8'h10;
	localparam logic [7:0] OFS_PEND = 8'h14;
	localparam logic [7:0] OFS_FLAG = 8'h18;
	localparam logic [7:0] OFS_ENABLE = 8'h1C;
	localparam logic [7:0] OFS_PRIO0 = 8'h20;
	localparam logic [7:0] OFS_PRIO1 = 8'h24;
	localparam logic [7:0] OFS_CORE = 8'h28;
	localparam int LVL_LSB = 5;
	localparam int NEST_BIT = 15;
	localparam int GIE_BIT = 15;
	localparam int DISABLE_INSTR_ACTIVE_BIT = 14;
	localparam int SOFTWARE_TRAP_ENABLE_BIT = 13;
	localparam int AIVT_BIT = 8;
	localparam int LVL_HI_BIT = 3;
	localparam int SOFT_HARD_TRAP_FLAG_BIT = 0;
	localparam int APLL_BIT = 0;
	localparam int DOOVF_BIT = 1;
	localparam logic [15:0] CTRL2_RST = 16'h8000;
	localparam logic [15:0] CTRL2_MASK = 16'hE117;
	localparam logic [7:0] VEC_OSC_FAIL = 8'h00;
	localparam logic [7:0] VEC_ADDR_ERR = 8'h01;
	localparam logic [7:0] VEC_HARD = 8'h02;
	localparam logic [7:0] VEC_STACK = 8'h03;
	localparam logic [7:0] VEC_MATH = 8'h04;
	localparam logic [7:0] VEC_SOFT = 8'h06;
	localparam logic [7:0] VEC_USER0 = 8'h08;
	localparam logic [7:0] VEC_NONE = 8'hFF;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : vpic_pkg

// >>> hdl/vpic_req_if.sv
`timescale 1ns/1ps
interface vpic_req_if;
	logic [vpic_pkg::NSRC-1:0] flag;
	logic [vpic_pkg::NSRC-1:0] enable;
	logic [3*vpic_pkg::NSRC-1:0] prio;
	logic [3:0] cpuLevel;
	logic globalEnable;
	logic [7:0] trapVec;
	logic trapValid;
	logic [7:0] bestVec;
	logic [3:0] bestLevel;
	logic bestValid;
	modport ctrl (output flag, enable, prio, cpuLevel, globalEnable,
		trapVec, trapValid, input bestVec, bestLevel, bestValid);
	modport arb (input flag, enable, prio, cpuLevel, globalEnable,
		trapVec, trapValid, output bestVec, bestLevel, bestValid);
endinterface : vpic_req_if
